// ===== rtl/ams_top.sv
// register file and steering logic for the channel 0 input multiplexer
// assumes an axi4-lite master, a sample strobe from the converter
// sequencer, and a pin-present mask tied off per package
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module ams_top (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [3:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic sample_done_i,
  input wire logic seq_restart_i,
  input wire logic [12:0] pin_present_i,
  output ams_pkg::ams_mux_type mux_o,
  output logic sample_b_o,
  output logic [3:0] scan_slot_o
);
  // reset release synchroniser
  logic rst_meta_ff;
  logic rst_sync_ff;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  wire logic rst_b;
  assign rst_b = rst_sync_ff;

  // apply byte strobes and an implemented-bit mask to a register
  function automatic logic [31:0] wr_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] strb,
                                           input logic [31:0] mask);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    wr_merge = res & mask;
  endfunction

  // leg for a pin number, low reference when the pin is absent
  function automatic ams_pkg::ams_leg_type pin_leg(input logic [3:0] n,
                                                   input logic [12:0] pres);
    ams_pkg::ams_leg_type l;
    l.pin = n;
    l.src = pres[n] ? ams_pkg::SRC_PIN : ams_pkg::SRC_LOW_REF;
    pin_leg = l;
  endfunction

  // state
  logic [31:0] in_sel_ff, nxt_in_sel;
  logic [15:0] scan_sel_ff, nxt_scan_sel;
  logic [31:0] ctrl_ff, nxt_ctrl;
  logic aw_got_ff, nxt_aw_got;
  logic w_got_ff, nxt_w_got;
  logic [3:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic sample_b_ff, nxt_sample_b;
  logic [3:0] scan_slot_ff, nxt_scan_slot;
  ams_pkg::ams_mux_type mux_ff, nxt_mux;

  // handshakes
  assign s_axi_awready_o = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready_o = !w_got_ff && !bvalid_ff;
  assign s_axi_arready_o = !rvalid_ff;
  assign s_axi_bvalid_o = bvalid_ff;
  assign s_axi_bresp_o = bresp_ff;
  assign s_axi_rvalid_o = rvalid_ff;
  assign s_axi_rdata_o = rdata_ff;
  assign s_axi_rresp_o = rresp_ff;

  // write channel capture, register write and response
  always_comb begin
    logic [3:0] a;
    logic [31:0] d;
    logic [3:0] s;
    a = aw_got_ff ? awaddr_ff : s_axi_awaddr_i;
    d = w_got_ff ? wdata_ff : s_axi_wdata_i;
    s = w_got_ff ? wstrb_ff : s_axi_wstrb_i;
    nxt_aw_got = aw_got_ff;
    nxt_w_got = w_got_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_in_sel = in_sel_ff;
    nxt_scan_sel = scan_sel_ff;
    nxt_ctrl = ctrl_ff;
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      nxt_aw_got = 1'b1;
      nxt_awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      nxt_w_got = 1'b1;
      nxt_wdata = s_axi_wdata_i;
      nxt_wstrb = s_axi_wstrb_i;
    end
    if (nxt_aw_got && nxt_w_got && !bvalid_ff) begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = ams_pkg::RESP_OKAY;
      if (a == ams_pkg::INPUT_SELECT_ADDR) begin
        nxt_in_sel = wr_merge(in_sel_ff, d, s,
                              ams_pkg::INPUT_SELECT_MASK);
      end else if (a == ams_pkg::SCAN_SELECT_ADDR) begin
        nxt_scan_sel = 16'(wr_merge({16'h0000, scan_sel_ff}, d, s,
                                    ams_pkg::SCAN_SELECT_MASK));
      end else if (a == ams_pkg::CONTROL_ADDR) begin
        nxt_ctrl = wr_merge(ctrl_ff, d, s, ams_pkg::CONTROL_MASK);
      end else begin
        nxt_bresp = ams_pkg::RESP_SLVERR;
      end
    end else if (bvalid_ff && s_axi_bready_i) begin
      nxt_bvalid = 1'b0;
    end
  end

  // read channel
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = ams_pkg::RESP_OKAY;
      if (s_axi_araddr_i == ams_pkg::INPUT_SELECT_ADDR) begin
        nxt_rdata = in_sel_ff;
      end else if (s_axi_araddr_i == ams_pkg::SCAN_SELECT_ADDR) begin
        nxt_rdata = {16'h0000, scan_sel_ff};
      end else if (s_axi_araddr_i == ams_pkg::CONTROL_ADDR) begin
        nxt_rdata = ctrl_ff;
      end else begin
        nxt_rdata = 32'h0000_0000;
        nxt_rresp = ams_pkg::RESP_SLVERR;
      end
    end else if (rvalid_ff && s_axi_rready_i) begin
      nxt_rvalid = 1'b0;
    end
  end

  // sample sequencing: alternate a/b and step the scan list
  always_comb begin
    logic found;
    logic [3:0] idx;
    found = 1'b0;
    idx = 4'h0;
    nxt_sample_b = sample_b_ff;
    nxt_scan_slot = scan_slot_ff;
    if (seq_restart_i || !ctrl_ff[ams_pkg::ALT_POS]) begin
      nxt_sample_b = 1'b0;
    end else if (sample_done_i) begin
      nxt_sample_b = !sample_b_ff;
    end
    if (seq_restart_i || !ctrl_ff[ams_pkg::SCAN_EN_POS]) begin
      // first listed member from slot 0
      for (int i = ams_pkg::SCAN_BITS - 1; i >= 0; i--) begin
        if (scan_sel_ff[i]) begin
          nxt_scan_slot = 4'(i);
        end
      end
      if (scan_sel_ff == 16'h0000) begin
        nxt_scan_slot = 4'h0;
      end
    end else if (sample_done_i) begin
      // next listed member after the current one, wrapping
      for (int k = 1; k <= ams_pkg::SCAN_BITS; k++) begin
        idx = 4'(scan_slot_ff + 4'(k));
        if (!found && scan_sel_ff[idx]) begin
          found = 1'b1;
          nxt_scan_slot = idx;
        end
      end
    end
  end

  // mux steering from the active settings
  always_comb begin
    logic [3:0] code;
    logic neg;
    code = 4'h0;
    neg = 1'b0;
    nxt_mux.pos = pin_leg(4'h0, pin_present_i);
    nxt_mux.neg = '{src: ams_pkg::SRC_LOW_REF, pin: 4'h0};
    if (sample_b_ff) begin
      code = in_sel_ff[ams_pkg::POS_SEL_B_LSB +: 4];
      neg = in_sel_ff[ams_pkg::NEG_SEL_B_POS];
    end else begin
      code = in_sel_ff[ams_pkg::POS_SEL_A_LSB +: 4];
      neg = in_sel_ff[ams_pkg::NEG_SEL_A_POS];
    end
    if (ctrl_ff[ams_pkg::OFFSET_CALIBRATION_POS]) begin
      nxt_mux.pos = '{src: ams_pkg::SRC_LOW_REF, pin: 4'h0};
    end else if (ctrl_ff[ams_pkg::SCAN_EN_POS] && !sample_b_ff &&
                 scan_sel_ff != 16'h0000) begin
      // scan replaces the sample a code; an empty list uses the code
      if (scan_slot_ff == ams_pkg::SCAN_CTU) begin
        nxt_mux.pos = '{src: ams_pkg::SRC_CTU, pin: 4'h0};
      end else if (scan_slot_ff == ams_pkg::SCAN_INTERNAL_ABS_REFERENCE) begin
        nxt_mux.pos = '{src: ams_pkg::SRC_INTERNAL_ABS_REFERENCE, pin: 4'h0};
      end else if (scan_slot_ff == ams_pkg::SCAN_GND) begin
        nxt_mux.pos = '{src: ams_pkg::SRC_GND, pin: 4'h0};
      end else begin
        nxt_mux.pos = pin_leg(scan_slot_ff, pin_present_i);
      end
    end else if (code <= ams_pkg::POS_LAST_PIN) begin
      nxt_mux.pos = pin_leg(code, pin_present_i);
    end else if (code == ams_pkg::POS_TEMP) begin
      nxt_mux.pos = '{src: ams_pkg::SRC_TEMP, pin: 4'h0};
    end else if (code == ams_pkg::POS_INTERNAL_ABS_REFERENCE) begin
      nxt_mux.pos = '{src: ams_pkg::SRC_INTERNAL_ABS_REFERENCE, pin: 4'h0};
    end else begin
      nxt_mux.pos = '{src: ams_pkg::SRC_OPEN, pin: 4'h0};
    end
    if (!ctrl_ff[ams_pkg::OFFSET_CALIBRATION_POS] && neg) begin
      nxt_mux.neg = pin_leg(4'h1, pin_present_i);
    end
  end

  // registers
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      in_sel_ff <= ams_pkg::INPUT_SELECT_RST;
      scan_sel_ff <= ams_pkg::SCAN_SELECT_RST;
      ctrl_ff <= ams_pkg::CONTROL_RST;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'b00;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'b00;
      sample_b_ff <= 1'b0;
      scan_slot_ff <= 4'h0;
      mux_ff <= '{pos: '{src: ams_pkg::SRC_LOW_REF, pin: 4'h0},
                  neg: '{src: ams_pkg::SRC_LOW_REF, pin: 4'h0}};
    end else begin
      in_sel_ff <= nxt_in_sel;
      scan_sel_ff <= nxt_scan_sel;
      ctrl_ff <= nxt_ctrl;
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      sample_b_ff <= nxt_sample_b;
      scan_slot_ff <= nxt_scan_slot;
      mux_ff <= nxt_mux;
    end
  end

  assign mux_o = mux_ff;
  assign sample_b_o = sample_b_ff;
  assign scan_slot_o = scan_slot_ff;
endmodule // ams_top
`default_nettype wire

// ===== rtl/ams_pkg.sv
// package for the converter input multiplexer select block
// assumes a 32-bit axi4-lite register bus on one clock
package ams_pkg;
  // register byte addresses
  localparam logic [3:0] INPUT_SELECT_ADDR = 4'h0;
  localparam logic [3:0] SCAN_SELECT_ADDR = 4'h4;
  localparam logic [3:0] CONTROL_ADDR = 4'h8;
  // input_select field positions
  localparam int NEG_SEL_B_POS = 31;
  localparam int POS_SEL_B_LSB = 24;
  localparam int NEG_SEL_A_POS = 23;
  localparam int POS_SEL_A_LSB = 16;
  // control field positions
  localparam int ALT_POS = 0;
  localparam int SCAN_EN_POS = 10;
  localparam int OFFSET_CALIBRATION_POS = 12;
  // write masks of implemented bits
  localparam logic [31:0] INPUT_SELECT_MASK = 32'h8f8f_0000;
  localparam logic [31:0] SCAN_SELECT_MASK = 32'h0000_ffff;
  localparam logic [31:0] CONTROL_MASK = 32'h0000_1401;
  // values after reset
  localparam logic [31:0] INPUT_SELECT_RST = 32'h0000_0000;
  localparam logic [15:0] SCAN_SELECT_RST = 16'h0000;
  localparam logic [31:0] CONTROL_RST = 32'h0000_0000;
  // positive input codes
  localparam logic [3:0] POS_LAST_PIN = 4'hc;
  localparam logic [3:0] POS_TEMP = 4'hd;
  localparam logic [3:0] POS_INTERNAL_ABS_REFERENCE = 4'he;
  localparam logic [3:0] POS_OPEN = 4'hf;
  // scan slots beyond the pins
  localparam logic [3:0] SCAN_CTU = 4'hd;
  localparam logic [3:0] SCAN_INTERNAL_ABS_REFERENCE = 4'he;
  localparam logic [3:0] SCAN_GND = 4'hf;
  localparam int NUM_PINS = 13;
  localparam int SCAN_BITS = 16;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // analog source selected for a mux leg
  typedef enum logic [2:0] {
    SRC_PIN, SRC_LOW_REF, SRC_TEMP, SRC_INTERNAL_ABS_REFERENCE, SRC_OPEN, SRC_CTU, SRC_GND
  } ams_src_type;

  // one leg of the mux: source kind and pin number
  typedef struct packed {
    ams_src_type src;
    logic [3:0] pin;
  } ams_leg_type;

  // full mux steering
  typedef struct packed {
    ams_leg_type pos;
    ams_leg_type neg;
  } ams_mux_type;
endpackage

// ===== tb/ams_top_assertions.sv
// port checker for the input mux select block
// assumes a bind onto ams_top and a single clock domain
`timescale 1ns/1ps
`default_nettype none
module ams_top_assertions (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [3:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic sample_done_i,
  input wire logic seq_restart_i,
  input wire logic [12:0] pin_present_i,
  input wire ams_pkg::ams_mux_type mux_o,
  input wire logic sample_b_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [3:0] ar_ff;
  logic [3:0] nxt_ar_ff;
  // remember the address of the read under way
  always_comb nxt_ar_ff = (s_axi_arvalid_i && s_axi_arready_o) ?
    s_axi_araddr_i : ar_ff;
  always_ff @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i) ar_ff <= 4'h0;
    else ar_ff <= nxt_ar_ff;
  sequence wr_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  sequence b_waits;
    s_axi_bvalid_o && !s_axi_bready_i;
  endsequence
  neg_leg_a: assert property (
    mux_o.neg.src == ams_pkg::SRC_LOW_REF ||
    (mux_o.neg.src == ams_pkg::SRC_PIN && mux_o.neg.pin == 4'h1))
    else $error("negative leg off its two choices");
  pos_pin_a: assert property (
    mux_o.pos.src == ams_pkg::SRC_PIN |->
    mux_o.pos.pin <= 4'hc && pin_present_i[mux_o.pos.pin])
    else $error("positive leg on a missing pin");
  wr_answer_a: assert property (wr_taken |=> s_axi_bvalid_o)
    else $error("write answer late");
  b_hold_a: assert property (b_waits |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read answer dropped");
  rd_zero_a: assert property (
    s_axi_rvalid_o && ar_ff == 4'h0 |->
    (s_axi_rdata_o & ~ams_pkg::INPUT_SELECT_MASK) == 32'h0000_0000)
    else $error("unused select bits read nonzero");
  alt_step_a: assert property (
    $rose(sample_b_o) |-> $past(sample_done_i) || $past(sample_done_i, 2))
    else $error("sample b without a finished sample");
  restart_a: assert property (seq_restart_i |-> ##[1:2] !sample_b_o)
    else $error("restart did not return to sample a");
endmodule // ams_top_assertions
bind ams_top ams_top_assertions i_chk (.clk_i, .rst_b_i, .s_axi_awvalid_i,
  .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
  .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i,
  .sample_done_i, .seq_restart_i, .pin_present_i, .mux_o, .sample_b_o);
`default_nettype wire

// ===== tb/ams_conv_model.sv
// converter sequencer stand-in: sample strobes and package pin mask
// assumes requests one at a time from the bench
`timescale 1ns/1ps
`default_nettype none
module ams_conv_model (
  input wire logic clk_i,
  input wire logic [1:0] req_i,
  input wire logic [3:0] lag_i,
  output logic sample_done_o = 1'b0,
  output logic seq_restart_o = 1'b0,
  output logic [12:0] pin_present_o,
  output logic busy_o = 1'b0
);
  logic [1:0] kind = 2'h0;
  logic [3:0] cnt = 4'h0;
  // pins six and seven absent, as on a small package
  assign pin_present_o = 13'h1f3f;
  // waits lag cycles, then pulses done (bit 0) or restart (bit 1)
  always @(posedge clk_i) begin
    sample_done_o <= 1'b0;
    seq_restart_o <= 1'b0;
    if (req_i != 2'h0 && !busy_o) begin
      kind <= req_i;
      cnt <= lag_i;
      busy_o <= 1'b1;
    end else if (busy_o && cnt == 4'h0) begin
      sample_done_o <= kind[0];
      seq_restart_o <= kind[1];
      busy_o <= 1'b0;
    end else if (busy_o) cnt <= cnt - 4'h1;
  end
endmodule // ams_conv_model
`default_nettype wire

// ===== tb/ams_top_tb.sv
// self-checking bench for the input mux select block
// assumes the converter model and the checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
module ams_top_tb;
  localparam ams_pkg::ams_leg_type LO = '{ams_pkg::SRC_LOW_REF, 4'h0};
  localparam ams_pkg::ams_leg_type ONE = '{ams_pkg::SRC_PIN, 4'h1};
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, bvalid, rvalid, awready, wready, arready;
  logic sample_b, done, restart, busy;
  logic [1:0] bresp, rresp, req = 2'h0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, lag = 4'h0, slot;
  logic [31:0] wdata = 32'h0000_0000, rdata, d = 32'h5f4c;
  logic [12:0] pres;
  logic [33:0] notes [$];
  logic [3:0] sl [5] = '{4'h2, 4'h6, 4'hd, 4'hf, 4'h2};
  ams_pkg::ams_mux_type mux;
  int bad_count = 0, compares = 0, i;
  ams_top i_dut (.clk_i, .rst_b_i, .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .sample_done_i(done), .seq_restart_i(restart),
    .pin_present_i(pres), .mux_o(mux), .sample_b_o(sample_b),
    .scan_slot_o(slot));
  ams_conv_model i_conv (.clk_i, .req_i(req), .lag_i(lag),
    .sample_done_o(done), .seq_restart_o(restart), .pin_present_o(pres),
    .busy_o(busy));
  // 200 MHz clock
  initial forever #2.5 clk_i = ~clk_i;
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected leg for a select code or a scan slot
  function automatic ams_pkg::ams_leg_type leg(input logic [3:0] c, bit sc);
    if (c <= 4'hc && pres[c]) leg = '{ams_pkg::SRC_PIN, c};
    else if (c <= 4'hc) leg = LO;
    else if (c == 4'he) leg = '{ams_pkg::SRC_INTERNAL_ABS_REFERENCE, 4'h0};
    else if (c == 4'hd) leg = '{sc ? ams_pkg::SRC_CTU : ams_pkg::SRC_TEMP, 4'h0};
    else leg = '{sc ? ams_pkg::SRC_GND : ams_pkg::SRC_OPEN, 4'h0};
  endfunction
  // pin number only matters on a pin source
  function automatic ams_pkg::ams_leg_type nrm(input ams_pkg::ams_leg_type l);
    nrm = l;
    if (l.src != ams_pkg::SRC_PIN) nrm.pin = 4'h0;
  endfunction
  task automatic mx(input ams_pkg::ams_leg_type p, ams_pkg::ams_leg_type n);
    repeat (3) @(posedge clk_i);
    check({20'h0_0000, nrm(mux.pos), nrm(mux.neg)}, {20'h0_0000, p, n});
  endtask
  // one bus transfer; the expected answer goes on the note queue
  task automatic xfer(bit w, logic [3:0] a, logic [31:0] v, logic [33:0] e);
    int n;
    notes.push_back(e);
    if (w) begin
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    for (n = 0; n < 60; n++) begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
      if ((w && bvalid) || (!w && rvalid)) break;
    end
    bready <= 1'b0;
    rready <= 1'b0;
    // let an edge pass so the next call never re-drives in this step
    @(posedge clk_i);
    if (n == 60) begin
      bad_count++;
      report_and_stop();
    end
  endtask
  // asks the converter stand-in for a done (1) or restart (2) pulse
  task automatic step(input logic [1:0] k);
    int n;
    req <= k;
    lag <= d[3:0];
    d = lfsr(d);
    @(posedge clk_i);
    req <= 2'h0;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_i);
      if (!busy) break;
    end
    if (n == 40) begin
      bad_count++;
      report_and_stop();
    end
  endtask
  // answers are compared in arrival order against the notes
  always @(posedge clk_i) begin
    if (bvalid && bready) check({bresp, 32'h0000_0000}, notes.pop_front());
    if (rvalid && rready) check({rresp, rdata}, notes.pop_front());
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    for (i = 0; i < 12; i += 4) xfer(0, i[3:0], 0, 34'h0_0000_0000);
    mx('{ams_pkg::SRC_PIN, 4'h0}, LO);
    $display("reset test done");
    for (i = 0; i < 4; i++) begin
      d = lfsr(d);
      xfer(1, 4'h0, d, 34'h0_0000_0000);
      xfer(0, 4'h0, 0, {2'h0, d & ams_pkg::INPUT_SELECT_MASK});
      xfer(1, 4'h4, ~d, 34'h0_0000_0000);
      xfer(0, 4'h4, 0, {2'h0, ~d & ams_pkg::SCAN_SELECT_MASK});
    end
    xfer(1, 4'hc, d, {ams_pkg::RESP_SLVERR, 32'h0000_0000});
    xfer(0, 4'hc, 0, {ams_pkg::RESP_SLVERR, 32'h0000_0000});
    $display("register test done");
    xfer(1, 4'h8, 32'h0000_0000, 34'h0_0000_0000);
    // open code only steered here, never converted
    for (i = 0; i < 16; i++) begin
      xfer(1, 4'h0, {8'h00, i[0], 3'h0, i[3:0], 16'h0000}, 34'h0_0000_0000);
      mx(leg(i[3:0], 0), i[0] ? ONE : LO);
    end
    $display("code test done");
    xfer(1, 4'h0, 32'h8503_0000, 34'h0_0000_0000);
    xfer(1, 4'h8, 32'h0000_0001, 34'h0_0000_0000);
    step(2'h2);
    mx(leg(4'h3, 0), LO);
    step(2'h1);
    mx(leg(4'h5, 0), ONE);
    check({33'h0_0000_0000, sample_b}, 34'h0_0000_0001);
    step(2'h1);
    mx(leg(4'h3, 0), LO);
    $display("alternate test done");
    xfer(1, 4'h4, 32'h0000_a044, 34'h0_0000_0000);
    xfer(1, 4'h8, 32'h0000_0400, 34'h0_0000_0000);
    for (i = 0; i < 5; i++) begin
      step(i == 0 ? 2'h2 : 2'h1);
      mx(leg(sl[i], 1), LO);
      check({30'h0000_0000, slot}, {30'h0000_0000, sl[i]});
    end
    xfer(1, 4'h8, 32'h0000_1400, 34'h0_0000_0000);
    mx(LO, LO);
    $display("scan and calibration test done");
    report_and_stop();
  end
endmodule // ams_top_tb
`default_nettype wire
